/* rtl/ctap_defs.svh */
`ifndef CTAP_DEFS_SVH
`define CTAP_DEFS_SVH
`define CTAP_WAYS         4
`define CTAP_LINES        256
`define CTAP_WORDS        4
`define CTAP_LINE_W       128
`define CTAP_TAG_W        20
`define CTAP_LRU_W        3
`define CTAP_IDX_LSB      4
`define CTAP_IDX_W        8
`define CTAP_WORD_LSB     2
`define CTAP_TAG_LSB      12
`define CTAP_SEL_LSB      2
`define CTAP_OP_LSB       0
`define CTAP_TS_VALID     10
`define CTAP_TS_LRU_LSB   7
`define CTAP_TS_DIRTY_LSB 3
`define CTAP_CTRL_MASK    32'h0000_0fff
`define CTAP_TS_MASK      32'hffff_f7f8
`define CTAP_PL0          2'h0
`endif

/* rtl/ctap_pkg.sv */
`include "ctap_defs.svh"
package ctap_pkg;
  typedef enum logic [1:0] {
    OP_BUF = 2'b00,
    OP_CWR = 2'b01,
    OP_CRD = 2'b10,
    OP_CFL = 2'b11
  } ctap_op_e;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_TAG  = 2'b01,
    SEL_DATA = 2'b10,
    SEL_NONE = 2'b11
  } ctap_regsel_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } ctap_state_e;

  typedef struct packed {
    logic [`CTAP_LINE_W-1:0] line;
  } ctap_buf_s;

  typedef struct packed {
    ctap_state_e                                               st;
    logic [31:0]                                               ctrl;
    logic [31:0]                                               tagst;
    logic [31:0]                                               rdata;
    logic                                                      reg_ack;
    logic                                                      reg_fault;
    logic                                                      acc_ack;
    logic                                                      acc_hit;
    logic [31:0]                                               acc_rdata;
    logic [`CTAP_WAYS-1:0][`CTAP_LINES-1:0]                    valid;
    logic [`CTAP_WAYS-1:0][`CTAP_LINES-1:0][`CTAP_WORDS-1:0]   dirty;
    logic [`CTAP_LINES-1:0][`CTAP_LRU_W-1:0]                   lru;
  } ctap_core_s;
endpackage

/* rtl/ctap_line_buf.sv */
`timescale 1ns/100ps
`include "ctap_defs.svh"
// one 16-byte line buffer: word-wise writes or whole-line load
module ctap_line_buf (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    wr_word,
  input  wire logic [1:0]              word_sel,
  input  wire logic [31:0]             word_in,
  input  wire logic                    ld_line,
  input  wire logic [`CTAP_LINE_W-1:0] line_in,
  output logic      [`CTAP_LINE_W-1:0] line_out
);
  ctap_pkg::ctap_buf_s s;
  ctap_pkg::ctap_buf_s n;

  // a line load wins over a word write; the core never asks both at once
  always_comb begin
    n = s;
    if (ld_line) begin
      n.line = line_in;
    end else if (wr_word) begin
      n.line[word_sel*32 +: 32] = word_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign line_out = s.line;
endmodule // ctap_line_buf

/* rtl/ctap_lru.sv */
`timescale 1ns/100ps
`include "ctap_defs.svh"
// replacement history update: bit0 pair 0/1, bit1 way0 of pair, bit2 way2 of pair
module ctap_lru (
  input  wire logic [`CTAP_LRU_W-1:0] lru_in,
  input  wire logic [1:0]             way,
  output logic      [`CTAP_LRU_W-1:0] lru_out
);
  // bit0 and the bit of the touched pair change; the other pair keeps its history
  always_comb begin
    lru_out = lru_in;
    lru_out[0] = ~way[1];
    if (way[1]) begin
      lru_out[2] = ~way[0];
    end else begin
      lru_out[1] = ~way[0];
    end
  end
endmodule // ctap_lru

/* rtl/ctap_core.sv */
`timescale 1ns/100ps
`include "ctap_defs.svh"
module ctap_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [1:0]  reg_sel,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [1:0]  cpl,
  input  wire logic        real_mode,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  output logic             reg_fault,
  output logic             op_busy,
  input  wire logic        acc_req,
  input  wire logic        acc_wr,
  input  wire logic [31:0] acc_addr,
  input  wire logic [31:0] acc_wdata,
  output logic             acc_ack,
  output logic             acc_hit,
  output logic      [31:0] acc_rdata
);
  localparam int NW = `CTAP_WAYS;
  localparam int NL = `CTAP_LINES;

  ctap_pkg::ctap_core_s s;
  ctap_pkg::ctap_core_s n;

  // tag and data stores: no reset, valid bits guard their contents
  logic [`CTAP_LINE_W-1:0] data_mem [NW][NL];
  logic [`CTAP_TAG_W-1:0]  tag_mem  [NW][NL];

  logic                    fill_wr;
  logic                    flush_ld;
  logic [`CTAP_LINE_W-1:0] fill_line;
  logic [`CTAP_LINE_W-1:0] flush_line;
  logic                    mem_we;
  logic [1:0]              mem_way;
  logic [`CTAP_IDX_W-1:0]  mem_idx;
  logic [`CTAP_TAG_W-1:0]  mem_tag;
  logic [`CTAP_LINE_W-1:0] mem_line;
  logic [`CTAP_LRU_W-1:0]  lru_next;
  logic [NW-1:0]           hit_vec;

  function automatic logic [1:0] enc_way(input logic [NW-1:0] v);
    enc_way = v[3] ? 2'h3 : (v[2] ? 2'h2 : (v[1] ? 2'h1 : 2'h0));
  endfunction

  function automatic logic priv_ok(input logic [1:0] pl, input logic rm);
    priv_ok = rm || (pl == `CTAP_PL0);
  endfunction

  // control register fields
  wire ctap_pkg::ctap_op_e     c_op  = ctap_pkg::ctap_op_e'(s.ctrl[`CTAP_OP_LSB +: 2]);
  wire logic [1:0]             c_sel = s.ctrl[`CTAP_SEL_LSB +: 2];
  wire logic [`CTAP_IDX_W-1:0] c_idx = s.ctrl[`CTAP_IDX_LSB +: `CTAP_IDX_W];

  // normal access address split
  wire logic [`CTAP_IDX_W-1:0] a_idx  = acc_addr[`CTAP_IDX_LSB +: `CTAP_IDX_W];
  wire logic [`CTAP_TAG_W-1:0] a_tag  = acc_addr[`CTAP_TAG_LSB +: `CTAP_TAG_W];
  wire logic [1:0]             a_word = acc_addr[`CTAP_WORD_LSB +: 2];
  wire logic [1:0]             a_way  = enc_way(hit_vec);
  wire logic                   a_hit  = |hit_vec;
  wire logic                   r_req  = reg_rd || reg_wr;
  wire ctap_pkg::ctap_regsel_e r_sel  = ctap_pkg::ctap_regsel_e'(reg_sel);

  // a way hits only when valid and its tag equals the upper address bits
  genvar gw;
  generate
    for (gw = 0; gw < NW; gw++) begin : g_hit
      assign hit_vec[gw] = s.valid[gw][a_idx] && (tag_mem[gw][a_idx] == a_tag);
    end
  endgenerate

  ctap_line_buf u_fill (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_word  (fill_wr),
    .word_sel (c_sel),
    .word_in  (reg_wdata),
    .ld_line  (1'b0),
    .line_in  ('0),
    .line_out (fill_line)
  );

  ctap_line_buf u_flush (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_word  (1'b0),
    .word_sel (2'h0),
    .word_in  (32'h0),
    .ld_line  (flush_ld),
    .line_in  (data_mem[c_sel][c_idx]),
    .line_out (flush_line)
  );

  ctap_lru u_lru (
    .lru_in  (s.lru[a_idx]),
    .way     (a_way),
    .lru_out (lru_next)
  );

  // next state: a started test operation runs alone in the cycle after the
  // control write, so register moves and cache accesses never race it
  always_comb begin
    n = s;
    n.reg_ack = 1'b0;
    n.reg_fault = 1'b0;
    n.acc_ack = 1'b0;
    fill_wr = 1'b0;
    flush_ld = 1'b0;
    mem_we = 1'b0;
    mem_way = c_sel;
    mem_idx = c_idx;
    mem_tag = s.tagst[`CTAP_TAG_LSB +: `CTAP_TAG_W];
    mem_line = fill_line;
    if (s.st == ctap_pkg::ST_EXEC) begin
      n.st = ctap_pkg::ST_IDLE;
      case (c_op)
        ctap_pkg::OP_CWR: begin
          mem_we = 1'b1;
          n.valid[c_sel][c_idx] = s.tagst[`CTAP_TS_VALID];
          n.dirty[c_sel][c_idx] = s.tagst[`CTAP_TS_DIRTY_LSB +: `CTAP_WORDS];
        end
        ctap_pkg::OP_CRD: begin
          flush_ld = 1'b1;
          n.tagst = {tag_mem[c_sel][c_idx], 1'b0, s.valid[c_sel][c_idx],
                     s.lru[c_idx], s.dirty[c_sel][c_idx], 3'h0};
        end
        ctap_pkg::OP_CFL: begin
          // no memory port here: flushing drops lines, write-back is outside
          n.valid = '0;
          n.dirty = '0;
        end
        default: begin
        end
      endcase
      if (acc_req) begin
        n.acc_ack = 1'b1;
        n.acc_hit = 1'b0;
      end
    end else begin
      if (r_req && !priv_ok(cpl, real_mode)) begin
        n.reg_fault = 1'b1;
      end else if (r_req) begin
        n.reg_ack = 1'b1;
        if (reg_wr) begin
          case (r_sel)
            ctap_pkg::SEL_CTRL: begin
              n.ctrl = reg_wdata & `CTAP_CTRL_MASK;
              if (reg_wdata[`CTAP_OP_LSB +: 2] != 2'h0) begin
                n.st = ctap_pkg::ST_EXEC;
              end
            end
            ctap_pkg::SEL_TAG: begin
              n.tagst = reg_wdata & `CTAP_TS_MASK;
            end
            ctap_pkg::SEL_DATA: begin
              fill_wr = (c_op == ctap_pkg::OP_BUF);
            end
            default: begin
            end
          endcase
        end else begin
          case (r_sel)
            ctap_pkg::SEL_CTRL: n.rdata = s.ctrl;
            ctap_pkg::SEL_TAG:  n.rdata = s.tagst;
            ctap_pkg::SEL_DATA: n.rdata = flush_line[c_sel*32 +: 32];
            default:            n.rdata = 32'h0;
          endcase
        end
      end
      if (acc_req) begin
        n.acc_ack = 1'b1;
        n.acc_hit = a_hit;
        n.acc_rdata = a_hit ? data_mem[a_way][a_idx][a_word*32 +: 32] : 32'h0;
        if (a_hit) begin
          n.lru[a_idx] = lru_next;
          if (acc_wr) begin
            // write-back: only the cached word changes, memory stays stale
            mem_we = 1'b1;
            mem_way = a_way;
            mem_idx = a_idx;
            mem_tag = a_tag;
            mem_line = data_mem[a_way][a_idx];
            mem_line[a_word*32 +: 32] = acc_wdata;
            n.dirty[a_way][a_idx][a_word] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // store writes; one writer per cycle by construction
  always_ff @(posedge clk) begin
    if (mem_we) begin
      data_mem[mem_way][mem_idx] <= mem_line;
      tag_mem[mem_way][mem_idx] <= mem_tag;
    end
  end

  assign reg_rdata = s.rdata;
  assign reg_ack = s.reg_ack;
  assign reg_fault = s.reg_fault;
  assign op_busy = (s.st == ctap_pkg::ST_EXEC);
  assign acc_ack = s.acc_ack;
  assign acc_hit = s.acc_hit;
  assign acc_rdata = s.acc_rdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence idle_req;
    !op_busy && r_req;
  endsequence

  sequence start_op;
    idle_req ##0 (priv_ok(cpl, real_mode) && reg_wr && r_sel == ctap_pkg::SEL_CTRL
                  && reg_wdata[1:0] != 2'h0);
  endsequence

  chk_fault_low_priv: assert property (
    idle_req ##0 !priv_ok(cpl, real_mode) |=> reg_fault && !reg_ack)
    else $error("test register move outside level 0 not refused");

  chk_ack_level0: assert property (
    idle_req ##0 priv_ok(cpl, real_mode) |=> reg_ack && !reg_fault)
    else $error("level 0 test register move not acknowledged");

  chk_busy_one_cycle: assert property (
    start_op |=> op_busy ##1 !op_busy)
    else $error("test operation busy not exactly one cycle");

  chk_ts_reserved: assert property (
    s.tagst[11] == 1'b0 && s.tagst[2:0] == 3'h0)
    else $error("reserved tag status bits not zero");

  chk_flush_clears: assert property (
    op_busy && c_op == ctap_pkg::OP_CFL |=> s.valid == '0 && s.dirty == '0)
    else $error("cache flush left valid or dirty bits");

  chk_invalid_miss: assert property (
    acc_req && !op_busy && s.valid[0][a_idx] == 1'b0 && s.valid[1][a_idx] == 1'b0
    && s.valid[2][a_idx] == 1'b0 && s.valid[3][a_idx] == 1'b0 |=> acc_ack && !acc_hit)
    else $error("hit reported on a line with no valid way");

  chk_write_dirty: assert property (
    acc_req && acc_wr && !op_busy && a_hit
    |=> s.dirty[$past(a_way)][$past(a_idx)][$past(a_word)])
    else $error("write hit did not mark its word dirty");

  chk_lru_pair: assert property (
    acc_req && !op_busy && a_hit |=> s.lru[$past(a_idx)][0] == ($past(a_way) < 2'h2))
    else $error("history bit does not name the accessed pair");

  chk_read_valid: assert property (
    op_busy && c_op == ctap_pkg::OP_CRD
    |=> s.tagst[`CTAP_TS_VALID] == $past(s.valid[c_sel][c_idx]))
    else $error("cache read returned wrong valid bit");
endmodule // ctap_core

/* sim/tb_ctap_core.sv */
`timescale 1ns/100ps
module tb_ctap_core;
  logic        clk;
  logic        rst_n;
  logic        reg_rd;
  logic        reg_wr;
  logic [1:0]  reg_sel;
  logic [31:0] reg_wdata;
  logic [1:0]  cpl;
  logic        real_mode;
  logic [31:0] reg_rdata;
  logic        reg_ack;
  logic        reg_fault;
  logic        op_busy;
  logic        acc_req;
  logic        acc_wr;
  logic [31:0] acc_addr;
  logic [31:0] acc_wdata;
  logic        acc_ack;
  logic        acc_hit;
  logic [31:0] acc_rdata;
  int          miscompares;
  int          cmp_count;

  ctap_core u_ctap_core (
    .clk       (clk),
    .rst_n     (rst_n),
    .reg_rd    (reg_rd),
    .reg_wr    (reg_wr),
    .reg_sel   (reg_sel),
    .reg_wdata (reg_wdata),
    .cpl       (cpl),
    .real_mode (real_mode),
    .reg_rdata (reg_rdata),
    .reg_ack   (reg_ack),
    .reg_fault (reg_fault),
    .op_busy   (op_busy),
    .acc_req   (acc_req),
    .acc_wr    (acc_wr),
    .acc_addr  (acc_addr),
    .acc_wdata (acc_wdata),
    .acc_ack   (acc_ack),
    .acc_hit   (acc_hit),
    .acc_rdata (acc_rdata)
  );

  // 40 MHz core clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // expected history after an access to one way
  function automatic logic [2:0] lru_nx(input logic [2:0] l, input logic [1:0] w);
    lru_nx = l;
    lru_nx[0] = (w < 2'h2);
    if (w < 2'h2) lru_nx[1] = (w == 2'h0);
    else lru_nx[2] = (w == 2'h2);
  endfunction

  // one register move; strobes stay up afterwards so back-to-back moves never
  // lower and raise them in one time step
  task automatic mv(input logic wr, input logic [1:0] sel, input logic [31:0] d,
                    output logic [31:0] q);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_sel = sel;
    reg_wdata = d;
    @(posedge clk);
    #2;
    chk(reg_ack, 1'h1, "move ack");
    q = reg_rdata;
  endtask

  // test operation; the busy cycle is let pass before the next move
  task automatic op(input logic [7:0] idx, input logic [1:0] way, input logic [1:0] code);
    logic [31:0] q;
    mv(1'h1, 2'h0, {20'h0, idx, way, code}, q);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    chk(op_busy, 1'h1, "busy");
    @(posedge clk);
    #2;
    chk(op_busy, 1'h0, "busy end");
  endtask

  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic h, output logic [31:0] q);
    acc_req = 1'h1;
    acc_wr = wr;
    acc_addr = a;
    acc_wdata = d;
    @(posedge clk);
    #2;
    chk(acc_ack, 1'h1, "access ack");
    h = acc_hit;
    q = acc_rdata;
  endtask

  // hang guard well beyond the run length
  initial begin
    #2500000;
    chk(1'h0, 1'h1, "timeout");
    finish_test();
  end

  initial begin : main
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] wd [4];
    logic [7:0]  idx;
    logic [19:0] tag;
    logic [3:0]  drt;
    logic [2:0]  lru;
    logic [1:0]  wi;
    logic [1:0]  wk;
    logic        h;
    {rst_n, reg_rd, reg_wr, real_mode, acc_req, acc_wr} = 6'h0;
    reg_sel = 2'h0;
    cpl = 2'h0;
    reg_wdata = 32'h0;
    acc_addr = 32'h0;
    acc_wdata = 32'h0;
    r = $urandom(32'h3170);
    repeat (3) @(posedge clk);
    #2 rst_n = 1'h1;
    chk({reg_ack, reg_fault, op_busy, acc_ack, acc_hit}, 32'h0, "reset flags");
    mv(1'h0, 2'h0, 32'h0, q);
    chk(q, 32'h0, "control after reset");
    // moves above level 0 outside real mode are refused
    reg_rd = 1'h0;
    reg_wr = 1'h1;
    reg_wdata = 32'h0000_0ff0;
    for (int c = 1; c < 4; c++) begin
      cpl = c[1:0];
      @(posedge clk);
      #2;
      chk(reg_fault, 1'h1, "fault");
      chk(reg_ack, 1'h0, "ack on fault");
    end
    real_mode = 1'h1;
    mv(1'h0, 2'h0, 32'h0, q);
    chk(q, 32'h0, "refused write took effect");
    real_mode = 1'h0;
    cpl = 2'h0;
    // register field masks, op kept at 00 to avoid launching operations
    repeat (4) begin
      r = $urandom & 32'hffff_fffc;
      mv(1'h1, 2'h0, r, q);
      mv(1'h0, 2'h0, 32'h0, q);
      chk(q, r & 32'h0000_0fff, "control readback");
      r = $urandom;
      mv(1'h1, 2'h1, r, q);
      mv(1'h0, 2'h1, 32'h0, q);
      chk(q, r & 32'hffff_f7f8, "tag status readback");
    end
    // fill each way of one line, hit it, write it, read it back
    idx = $urandom;
    tag = $urandom;
    lru = 3'h0;
    for (int w = 0; w < 4; w++) begin
      wi = w[1:0];
      drt = $urandom;
      for (int i = 0; i < 4; i++) begin
        wd[i] = $urandom;
        mv(1'h1, 2'h0, {20'h0, idx, i[1:0], 2'h0}, q);
        mv(1'h1, 2'h2, wd[i], q);
      end
      mv(1'h1, 2'h1, {tag[19:2], wi, 1'h0, 1'h1, 3'h0, drt, 3'h0}, q);
      op(idx, wi, 2'h1);
      wk = $urandom;
      acc(1'h0, {tag[19:2], wi, idx, wk, 2'h0}, 32'h0, h, q);
      chk(h, 1'h1, "read hit");
      chk(q, wd[wk], "read data");
      r = $urandom;
      acc(1'h1, {tag[19:2], wi, idx, wk, 2'h0}, r, h, q);
      chk(h, 1'h1, "write hit");
      acc_req = 1'h0;
      wd[wk] = r;
      drt[wk] = 1'h1;
      lru = lru_nx(lru, wi);
      op(idx, wi, 2'h2);
      mv(1'h0, 2'h1, 32'h0, q);
      chk(q, {tag[19:2], wi, 1'h0, 1'h1, lru, drt, 3'h0}, "entry state");
      for (int i = 0; i < 4; i++) begin
        mv(1'h1, 2'h0, {20'h0, idx, i[1:0], 2'h0}, q);
        mv(1'h0, 2'h2, 32'h0, q);
        chk(q, wd[i], "flush buffer word");
      end
    end
    // flush drops every line without allocation on the misses
    op(idx, 2'h0, 2'h3);
    for (int w = 0; w < 4; w++) begin
      acc(1'h0, {tag[19:2], w[1:0], idx, 4'h0}, 32'h0, h, q);
      chk(h, 1'h0, "hit after flush");
      chk(q, 32'h0, "miss data");
    end
    acc_req = 1'h0;
    op(idx, 2'h0, 2'h2);
    mv(1'h0, 2'h1, 32'h0, q);
    chk(q & 32'h0000_0478, 32'h0, "valid and dirty after flush");
    finish_test();
  end
endmodule // tb_ctap_core
